/* File: src/rodr_defines.svh */
// constants for the rail on/off request register bank
`ifndef RODR_DEFINES_SVH
`define RODR_DEFINES_SVH

`define RODR_ADDR_W        8
`define RODR_DATA_W        16
`define RODR_RAIL_CNT      7
`define RODR_ADDR_RAIL     8'h00
`define RODR_ADDR_GATE     8'h01

// rail_on_off_request: the off request for rail n is data bit n+8
`define RODR_ON_MSB        6
`define RODR_ON_LSB        0
`define RODR_OFF_MSB       14
`define RODR_OFF_LSB       8
`define RODR_PREREG_OFF    15

// gate_drive_and_ldo_request
`define RODR_HS_PD_MSB     1
`define RODR_HS_PD_LSB     0
`define RODR_LS_MSB        3
`define RODR_LS_LSB        2
`define RODR_BST_MSB       5
`define RODR_BST_LSB       4
`define RODR_PD_OVR        6
`define RODR_HV_ON         7
`define RODR_HV_OFF        8
`define RODR_HS_PU_MSB     13
`define RODR_HS_PU_LSB     12

`define RODR_ZERO16        16'h0000
`define RODR_ZERO2         2'h0

// drive strength and slew codes
`define RODR_DRV_130MA     2'h0
`define RODR_DRV_260MA     2'h1
`define RODR_DRV_520MA     2'h2
`define RODR_DRV_900MA     2'h3
`define RODR_SLEW_50       2'h0
`define RODR_SLEW_100      2'h1
`define RODR_SLEW_300      2'h2
`define RODR_SLEW_500      2'h3

`endif

/* File: src/rodr_pkg.sv */
// types shared by the rail on/off request register bank
`include "rodr_defines.svh"

package rodr_pkg;

    typedef struct packed {
        logic                       prereg_off_req;
        logic                       hv_linear_on_req;
        logic                       hv_linear_off_req;
        logic [`RODR_RAIL_CNT-1:0]  rail_off_req;
        logic [`RODR_RAIL_CNT-1:0]  rail_on_req;
    } rodr_req_type;

    typedef struct packed {
        logic [1:0] prereg_hs_pullup_drive;
        logic [1:0] boost_ls_slew;
        logic [1:0] prereg_ls_drive;
        logic [1:0] prereg_hs_pulldown_drive;
    } rodr_otp_type;

    typedef struct packed {
        logic         prereg_pulldown_override;
        rodr_otp_type drive;
    } rodr_cfg_type;

    typedef enum logic {
        RODR_LOAD_OTP,
        RODR_RUN
    } rodr_state_type;

endpackage

/* File: src/rodr_pulse_gen.sv */
// one-cycle strobe generator, one flop per request bit
`timescale 1ns/10ps
`default_nettype none

module rodr_pulse_gen
    import rodr_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_n_in,
    // write strobe and data
    input  wire logic          fire_in,
    input  wire logic [W-1:0]  bits_in,
    // strobes
    output logic      [W-1:0]  pulse_out
);

    logic [W-1:0] next_pulse;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            // a 1 raises the strobe, a 0 does nothing; never held
            always_comb begin
                next_pulse[g] = fire_in & bits_in[g];
            end

            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    pulse_out[g] <= 1'b0;
                end else begin
                    pulse_out[g] <= next_pulse[g];
                end
            end
        end
    endgenerate

endmodule // rodr_pulse_gen

`default_nettype wire

/* File: src/rodr_regs.sv */
// rail on/off request and gate drive register bank
`timescale 1ns/10ps
`default_nettype none
`include "rodr_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RULE1 - writing 1 to enable bit requests rail on
// RULE2 - writing 0 to request bits does nothing
// RULE3 - writing 1 to disable bit requests rail off
// RULE4 - top bit requests pre-regulator shutdown
// RULE5 - high-side pull-down drive field, reset from otp
// RULE6 - low-side drive field, reset from otp
// RULE7 - boost low-side slew field, read/write, otp reset
// RULE8 - override bit forces pull-down off when 1
// RULE9 - high-side pull-up drive field, four strengths
// RULE10 - boost slew codes 50 to 500 V/us
// RULE11 - request bits are strobes, read as zero
module rodr_regs
    import rodr_pkg::*;
(
    // clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     rst_n_in,
    // register port
    input  wire logic                     reg_wr_in,
    input  wire logic                     reg_rd_in,
    input  wire logic [`RODR_ADDR_W-1:0]  reg_addr_in,
    input  wire logic [`RODR_DATA_W-1:0]  reg_wdata_in,
    output logic      [`RODR_DATA_W-1:0]  reg_rdata_out,
    output logic                          reg_rvalid_out,
    // programmed configuration
    input  wire rodr_otp_type             otp_cfg_in,
    // requests to the sequencer
    output rodr_req_type                  req_out,
    // drive settings
    output rodr_cfg_type                  cfg_out,
    output logic                          prereg_pulldown_off_out
);

    ////////////////////////////////////////////////////////////////////////////
    // decode

    function automatic logic hit(input logic [`RODR_ADDR_W-1:0] a,
                                 input logic [`RODR_ADDR_W-1:0] want);
        hit = (a == want);
    endfunction

    logic wr_rail;
    logic wr_gate;
    assign wr_rail = reg_wr_in & hit(reg_addr_in, `RODR_ADDR_RAIL);
    assign wr_gate = reg_wr_in & hit(reg_addr_in, `RODR_ADDR_GATE);

    ////////////////////////////////////////////////////////////////////////////
    // request strobes

    rodr_pulse_gen #(.W(2 * `RODR_RAIL_CNT + 1)) u_rail_pulse ( // RULE1 RULE3 RULE4
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .fire_in   (wr_rail),
        .bits_in   ({reg_wdata_in[`RODR_PREREG_OFF:`RODR_OFF_LSB],
                     reg_wdata_in[`RODR_ON_MSB:`RODR_ON_LSB]}),
        .pulse_out ({req_out.prereg_off_req, req_out.rail_off_req, req_out.rail_on_req})
    );

    rodr_pulse_gen #(.W(2)) u_hv_pulse ( // RULE2
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .fire_in   (wr_gate),
        .bits_in   ({reg_wdata_in[`RODR_HV_OFF], reg_wdata_in[`RODR_HV_ON]}),
        .pulse_out ({req_out.hv_linear_off_req, req_out.hv_linear_on_req})
    );

    ////////////////////////////////////////////////////////////////////////////
    // configuration register with otp load after reset release

    rodr_state_type state;
    rodr_state_type next_state;
    rodr_cfg_type   cfg;
    rodr_cfg_type   next_cfg;

    always_comb begin
        next_state = state;
        next_cfg   = cfg;
        unique case (state)
            RODR_LOAD_OTP: begin
                next_cfg.drive                    = otp_cfg_in; // RULE5 RULE6 RULE7
                next_cfg.prereg_pulldown_override = 1'b0;
                next_state                        = RODR_RUN;
            end
            RODR_RUN: begin
                if (wr_gate) begin
                    next_cfg.drive.prereg_hs_pulldown_drive =
                        reg_wdata_in[`RODR_HS_PD_MSB:`RODR_HS_PD_LSB]; // RULE5
                    next_cfg.drive.prereg_ls_drive =
                        reg_wdata_in[`RODR_LS_MSB:`RODR_LS_LSB]; // RULE6
                    next_cfg.drive.boost_ls_slew =
                        reg_wdata_in[`RODR_BST_MSB:`RODR_BST_LSB]; // RULE7 RULE10
                    next_cfg.drive.prereg_hs_pullup_drive =
                        reg_wdata_in[`RODR_HS_PU_MSB:`RODR_HS_PU_LSB]; // RULE9
                    next_cfg.prereg_pulldown_override =
                        reg_wdata_in[`RODR_PD_OVR]; // RULE8
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= RODR_LOAD_OTP;
            cfg   <= '0;
        end else begin
            state <= next_state;
            cfg   <= next_cfg;
        end
    end

    assign cfg_out                 = cfg;
    assign prereg_pulldown_off_out = cfg.prereg_pulldown_override; // RULE8

    ////////////////////////////////////////////////////////////////////////////
    // read path

    logic [`RODR_DATA_W-1:0] next_rdata;
    logic                    next_rvalid;

    always_comb begin
        next_rdata  = reg_rdata_out;
        next_rvalid = reg_rd_in;
        if (reg_rd_in) begin
            next_rdata = `RODR_ZERO16; // RULE11
            if (hit(reg_addr_in, `RODR_ADDR_GATE)) begin
                next_rdata[`RODR_HS_PD_MSB:`RODR_HS_PD_LSB] =
                    cfg.drive.prereg_hs_pulldown_drive;
                next_rdata[`RODR_LS_MSB:`RODR_LS_LSB]   = cfg.drive.prereg_ls_drive;
                next_rdata[`RODR_BST_MSB:`RODR_BST_LSB] = cfg.drive.boost_ls_slew; // RULE7
                next_rdata[`RODR_PD_OVR]                = cfg.prereg_pulldown_override;
                next_rdata[`RODR_HS_PU_MSB:`RODR_HS_PU_LSB] =
                    cfg.drive.prereg_hs_pullup_drive;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out  <= `RODR_ZERO16;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rdata_out  <= next_rdata;
            reg_rvalid_out <= next_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic running;
    assign running = (state == RODR_RUN);

    property p_on_req;
        @(posedge clk_in) disable iff (!rst_n_in)
        wr_rail |=> req_out.rail_on_req == $past(reg_wdata_in[`RODR_ON_MSB:`RODR_ON_LSB]);
    endproperty
    a_on_req: assert property (p_on_req) else $error("on strobe mismatch"); // RULE1

    property p_idle_quiet;
        @(posedge clk_in) disable iff (!rst_n_in)
        !wr_rail |=> (req_out.rail_on_req == '0) && (req_out.rail_off_req == '0)
                     && !req_out.prereg_off_req;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("strobe without write"); // RULE2

    property p_off_req;
        @(posedge clk_in) disable iff (!rst_n_in)
        wr_rail |=> req_out.rail_off_req == $past(reg_wdata_in[`RODR_OFF_MSB:`RODR_OFF_LSB]);
    endproperty
    a_off_req: assert property (p_off_req) else $error("off strobe mismatch"); // RULE3

    property p_prereg_off;
        @(posedge clk_in) disable iff (!rst_n_in)
        (wr_rail && reg_wdata_in[`RODR_PREREG_OFF]) |=> req_out.prereg_off_req ##1
            !req_out.prereg_off_req || $past(wr_rail);
    endproperty
    a_prereg_off: assert property (p_prereg_off) else $error("prereg strobe wrong"); // RULE4

    property p_hs_pd;
        @(posedge clk_in) disable iff (!rst_n_in)
        (running && wr_gate) |=> cfg_out.drive.prereg_hs_pulldown_drive ==
            $past(reg_wdata_in[`RODR_HS_PD_MSB:`RODR_HS_PD_LSB]);
    endproperty
    a_hs_pd: assert property (p_hs_pd) else $error("hs pull-down drive not written"); // RULE5

    property p_otp_load;
        @(posedge clk_in) disable iff (!rst_n_in)
        !running |=> cfg_out.drive == $past(otp_cfg_in) && running;
    endproperty
    a_otp_load: assert property (p_otp_load) else $error("otp not loaded"); // RULE6

    property p_cfg_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        (running && !wr_gate) |=> $stable(cfg_out);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("cfg changed without write"); // RULE7

    property p_override;
        @(posedge clk_in) disable iff (!rst_n_in)
        (running && wr_gate) |=> prereg_pulldown_off_out == $past(reg_wdata_in[`RODR_PD_OVR]);
    endproperty
    a_override: assert property (p_override) else $error("override not applied"); // RULE8

    property p_pullup;
        @(posedge clk_in) disable iff (!rst_n_in)
        (running && wr_gate) |=> cfg_out.drive.prereg_hs_pullup_drive ==
            $past(reg_wdata_in[`RODR_HS_PU_MSB:`RODR_HS_PU_LSB]);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up drive not written"); // RULE9

    property p_rail_reads_zero;
        @(posedge clk_in) disable iff (!rst_n_in)
        (reg_rd_in && hit(reg_addr_in, `RODR_ADDR_RAIL)) |=>
            reg_rvalid_out && (reg_rdata_out == `RODR_ZERO16);
    endproperty
    a_rail_reads_zero: assert property (p_rail_reads_zero) else $error("request read nonzero"); // RULE11

endmodule // rodr_regs

`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the rail on/off request register bank
`timescale 1ns/10ps
`default_nettype none
`include "rodr_defines.svh"

`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin fails++; \
    $display("FAIL %0t %s", $time, msg); end end

module tb_top
    import rodr_pkg::*;
;

    ////////////////////////////////////////////////////////////////////////////
    logic                      clk_in;
    logic                      rst_n_in;
    logic                      reg_wr_in;
    logic                      reg_rd_in;
    logic [`RODR_ADDR_W-1:0]   reg_addr_in;
    logic [`RODR_DATA_W-1:0]   reg_wdata_in;
    logic [`RODR_DATA_W-1:0]   reg_rdata_out;
    logic                      reg_rvalid_out;
    rodr_otp_type              otp_cfg_in;
    rodr_req_type              req_out;
    rodr_cfg_type              cfg_out;
    logic                      prereg_pulldown_off_out;
    int                        fails;
    int                        n_checks;
    rodr_req_type              exp_req;
    logic [15:0]               d;

    rodr_regs rodr_regs_inst (
        .clk_in                  (clk_in),
        .rst_n_in                (rst_n_in),
        .reg_wr_in               (reg_wr_in),
        .reg_rd_in               (reg_rd_in),
        .reg_addr_in             (reg_addr_in),
        .reg_wdata_in            (reg_wdata_in),
        .reg_rdata_out           (reg_rdata_out),
        .reg_rvalid_out          (reg_rvalid_out),
        .otp_cfg_in              (otp_cfg_in),
        .req_out                 (req_out),
        .cfg_out                 (cfg_out),
        .prereg_pulldown_off_out (prereg_pulldown_off_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    always #12.5 clk_in = ~clk_in;

    task automatic tick();
        @(posedge clk_in);
        #1;
    endtask

    // single write, returns 1 ns after the taking edge
    task automatic reg_write(input logic [7:0] a, input logic [15:0] wd);
        reg_wr_in    = 1'b1;
        reg_addr_in  = a;
        reg_wdata_in = wd;
        tick();
        reg_wr_in    = 1'b0;
    endtask

    // single read, compares data in the valid cycle
    task automatic reg_read(input logic [7:0] a, input logic [15:0] exp);
        reg_rd_in   = 1'b1;
        reg_addr_in = a;
        tick();
        reg_rd_in   = 1'b0;
        `CHK(reg_rvalid_out, 1'b1, "read valid missing")
        `CHK(reg_rdata_out, exp, "read data")
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0; rst_n_in = 1'b0; reg_wr_in = 1'b0; reg_rd_in = 1'b0;
        reg_addr_in = 8'h00; reg_wdata_in = 16'h0000; otp_cfg_in = 8'h9C;
        fails = 0; n_checks = 0;
        repeat (5) tick();
        `CHK(req_out, 17'h00000, "req during reset")
        `CHK(cfg_out, 9'h000, "cfg during reset")
        rst_n_in = 1'b1;
        tick();
        tick();
        `CHK(cfg_out.drive, otp_cfg_in, "drive not loaded")
        reg_read(`RODR_ADDR_GATE, 16'h201C);
        $display("test reset done");
        // back-to-back single-bit writes over the whole strobe register
        reg_wr_in   = 1'b1;
        reg_addr_in = `RODR_ADDR_RAIL;
        for (int i = 0; i < 16; i++) begin
            reg_wdata_in = 16'h0001 << i;
            tick();
            exp_req            = '0;
            exp_req.rail_on_req    = reg_wdata_in[`RODR_ON_MSB:`RODR_ON_LSB];
            exp_req.rail_off_req   = reg_wdata_in[`RODR_OFF_MSB:`RODR_OFF_LSB];
            exp_req.prereg_off_req = reg_wdata_in[`RODR_PREREG_OFF];
            `CHK(req_out.rail_on_req, exp_req.rail_on_req, "on strobe")
            `CHK(req_out.rail_off_req, exp_req.rail_off_req, "off strobe")
            `CHK(req_out, exp_req, "strobe set")
        end
        reg_wr_in = 1'b0;
        tick();
        `CHK(req_out, 17'h00000, "strobe held")
        reg_write(`RODR_ADDR_RAIL, 16'h0000);
        `CHK(req_out, 17'h00000, "zero write acted")
        `CHK(cfg_out.drive, otp_cfg_in, "zero write changed cfg")
        reg_read(`RODR_ADDR_RAIL, 16'h0000);
        $display("test strobes done");
        // every code of every drive field, reserved bits set
        for (int c = 0; c < 4; c++) begin
            d = 16'hCE00 | (16'(c) << 12) | (16'(3 - c) << 4) | (16'(c) << 2) | 16'(3 - c);
            d[6] = c[0];
            d[7] = (c == 1);
            d[8] = (c == 2);
            reg_write(`RODR_ADDR_GATE, d);
            `CHK(reg_rvalid_out, 1'b0, "read valid held")
            `CHK(req_out.hv_linear_on_req, d[7], "hv on strobe")
            `CHK(req_out.hv_linear_off_req, d[8], "hv off strobe")
            `CHK(cfg_out.drive.prereg_hs_pulldown_drive, d[1:0], "hs pull-down")
            `CHK(cfg_out.drive.prereg_ls_drive, d[3:2], "ls drive")
            `CHK(cfg_out.drive.boost_ls_slew, d[5:4], "boost slew")
            `CHK(cfg_out.drive.prereg_hs_pullup_drive, d[13:12], "hs pull-up")
            `CHK(cfg_out.prereg_pulldown_override, d[6], "override")
            `CHK(prereg_pulldown_off_out, d[6], "pull-down off")
            reg_read(`RODR_ADDR_GATE, d & 16'h307F);
            `CHK(req_out, 17'h00000, "hv strobe held")
        end
        $display("test drive fields done");
        // unmapped address leaves everything alone
        reg_write(8'h02, 16'hFFFF);
        `CHK(req_out, 17'h00000, "unmapped write strobed")
        `CHK(cfg_out.drive.boost_ls_slew, d[5:4], "unmapped write changed cfg")
        reg_read(8'h02, 16'h0000);
        $display("test unmapped done");
        // mid-run reset reloads the programmed drive and drops the override
        otp_cfg_in = 8'h63;
        rst_n_in   = 1'b0;
        tick();
        `CHK(cfg_out, 9'h000, "cfg in mid-run reset")
        rst_n_in = 1'b1;
        reg_write(`RODR_ADDR_GATE, 16'h0040);
        `CHK(cfg_out, {1'b0, otp_cfg_in}, "otp not reloaded")
        `CHK(req_out, 17'h00000, "strobe after reset")
        $display("test mid-run reset done");
        test_done();
    end

    initial begin
        repeat (2000) @(posedge clk_in);
        fails++;
        $display("FAIL %0t watchdog expired", $time);
        test_done();
    end

endmodule // tb_top

`default_nettype wire
